/* File: rtl/pscg_defs.svh */
// Purpose: offsets, fields and reset values of the power-saving clock block
// Assumes: 32-bit AHB-Lite word registers
// Notes: one macro per number
`ifndef PSCG_DEFS_SVH
`define PSCG_DEFS_SVH
`define PSCG_OFS_CLOCK_DIVIDER_REGISTER 4'h0
`define PSCG_OFS_GATE1 4'h4
`define PSCG_OFS_NEWSRC 4'h8
`define PSCG_OFS_STATUS 4'hC
`define PSCG_ROI_BIT 15
`define PSCG_RATIO_HI 14
`define PSCG_RATIO_LO 12
`define PSCG_DOZE_ENABLE_BIT_BIT 11
`define PSCG_NSRC_HI 10
`define PSCG_NSRC_LO 8
`define PSCG_CLOCK_DIVIDER_REGISTER_RST 16'h0000
`define PSCG_GATE1_RST 16'h0000
`define PSCG_GATE1_MASK 16'h3AA9
`define PSCG_NSRC_RST 3'h0
`define PSCG_RATIO_MAX 7'h7F
`define PSCG_GATE_DELAY 1
`define PSCG_HTRANS_NSEQ 2'h2
`endif

/* File: rtl/pscg_pkg.sv */
// Purpose: types shared by the power-saving clock block
// Assumes: nothing beyond the defs header
// Notes: states are one-hot
package pscg_pkg;
    typedef enum logic [4:0] {
        PSCG_RUN = 5'b00001,
        PSCG_ENT_SLEEP = 5'b00010,
        PSCG_ENT_IDLE = 5'b00100,
        PSCG_SLEEP = 5'b01000,
        PSCG_IDLE = 5'b10000
    } pscg_state_t;
    typedef struct packed {
        logic valid;
        logic idle_sel;
    } pscg_psv_t;
    typedef struct packed {
        logic irq;
        logic wdt_timeout;
        logic wdt_en;
        logic fail_safe_clock_monitor_en;
        logic clksw_en;
        logic [2:0] cfg_src;
    } pscg_sys_t;
endpackage

/* File: rtl/pscg_top.sv */
// Purpose: sleep, idle, doze and per-module clock gating
// Assumes: one 100 MHz clock; instruction cycle is one clock
// Notes: all side inputs come from same-clock logic
// Overview of operation
// RULE1: Sleep instruction stops system clock and CPU until a wake event.
// RULE2: Idle instruction stops CPU, system clock keeps feeding peripherals.
// RULE3: Enabled interrupt, watchdog time-out or reset ends Sleep or Idle.
// RULE4: Sleep turns off clock source; fail-safe monitor does not run.
// RULE5: Low-power RC runs in Sleep while watchdog is enabled.
// RULE6: Watchdog count cleared on entry to Sleep or Idle if enabled.
// RULE7: Sleep disables all system-clocked peripherals.
// RULE8: Wake from Sleep resumes on the clock source used at entry.
// RULE9: Idle keeps source on; RC on if watchdog or monitor enabled.
// RULE10: Idle wake reapplies CPU clock immediately.
// RULE11: Interrupt during entry is held, then wakes at once.
// RULE12: Doze slows only the CPU clock, peripherals keep full rate.
// RULE13: Doze acts only while doze enable bit 11 is set.
// RULE14: Ratio bits 14:12 pick 1:1 up to 1:128, default 1:1.
// RULE15: Recover bit 15 set makes interrupt return CPU to full speed.
// RULE16: Gate bit set stops module clock and its register access.
// RULE17: Module runs only if present and gate clear; gates reset enabled.
// RULE18: Gate change reaches the module one instruction cycle later.
// RULE19: Gate bits: 13,12,11 timers, 9 pulse, 7,5,3 serial, 0 converter.
// RULE20: Unused gate bits read zero and ignore writes.
// RULE21: New source writes ignored while clock switching disabled.
// RULE22: Doze divider counts system clocks, one CPU enable per period.
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pscg_defs.svh"
module pscg_top #(
    parameter logic [15:0] PRESENT_MASK = `PSCG_GATE1_MASK
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire pscg_pkg::pscg_psv_t I_PSV,
    input wire pscg_pkg::pscg_sys_t I_SYS,
    output logic O_CPU_CLK_EN,
    output logic O_SYS_CLK_EN,
    output logic O_LOW_POWER_RC_OSCILLATOR_EN,
    output logic O_FAIL_SAFE_CLOCK_MONITOR_RUN,
    output logic O_WDT_CLEAR,
    output logic O_WAKE,
    output logic [2:0] O_CLK_SRC,
    output logic [15:0] O_PERIPH_EN
);
    import pscg_pkg::*;

    pscg_state_t state_reg, state_next;
    logic [15:0] clock_divider_register_reg, clock_divider_register_next;
    logic [15:0] gate_reg, gate_next;
    logic [15:0] gate_dly_reg, gate_dly_next;
    logic [2:0] nsrc_reg, nsrc_next;
    logic [2:0] src_reg, src_next;
    logic [6:0] div_reg, div_next;
    logic held_irq_reg, held_irq_next;
    logic wdt_clr_reg, wdt_clr_next;
    logic wake_reg, wake_next;
    logic wr_pend_reg, wr_pend_next;
    logic [3:0] wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic addr_take, wake_evt, doze_on, cpu_tick;
    logic [6:0] ratio_top;

    // Ratio code to divider terminal count
    function automatic logic [6:0] ratio_to_top(input logic [2:0] code);
        ratio_to_top = `PSCG_RATIO_MAX >> (3'h7 - code);
    endfunction

    // Word-aligned register offset from byte address
    function automatic logic [3:0] word_ofs(input logic [31:0] addr);
        word_ofs = {addr[3:2], 2'h0};
    endfunction

    assign addr_take = I_HSEL && I_HREADY && I_HTRANS == `PSCG_HTRANS_NSEQ;
    // RULE3: wake sources
    assign wake_evt = I_SYS.irq || I_SYS.wdt_timeout || held_irq_reg;
    // RULE13: doze gated by enable bit
    assign doze_on = clock_divider_register_reg[`PSCG_DOZE_ENABLE_BIT_BIT];
    assign ratio_top = ratio_to_top(clock_divider_register_reg[`PSCG_RATIO_HI:`PSCG_RATIO_LO]);
    assign cpu_tick = (div_reg == 7'h00);

    // Power-save state machine
    always_comb begin
        state_next = state_reg;
        held_irq_next = 1'b0;
        wdt_clr_next = 1'b0;
        wake_next = 1'b0;
        case (state_reg)
            PSCG_RUN: begin
                if (I_PSV.valid) begin
                    // RULE6: clear watchdog on entry
                    wdt_clr_next = I_SYS.wdt_en;
                    state_next = I_PSV.idle_sel ? PSCG_ENT_IDLE : PSCG_ENT_SLEEP;
                end
            end
            PSCG_ENT_SLEEP: begin
                // RULE11: hold coincident interrupt
                held_irq_next = I_SYS.irq;
                state_next = PSCG_SLEEP;
            end
            PSCG_ENT_IDLE: begin
                held_irq_next = I_SYS.irq;
                state_next = PSCG_IDLE;
            end
            PSCG_SLEEP, PSCG_IDLE: begin
                // RULE10: resume at once on wake
                if (wake_evt) begin
                    wake_next = 1'b1;
                    state_next = PSCG_RUN;
                end
            end
            default: state_next = PSCG_RUN;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_reg <= PSCG_RUN;
            held_irq_reg <= 1'b0;
            wdt_clr_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            held_irq_reg <= held_irq_next;
            wdt_clr_reg <= wdt_clr_next;
            wake_reg <= wake_next;
        end
    end

    // Register file and bus slave, zero wait states
    always_comb begin
        clock_divider_register_next = clock_divider_register_reg;
        gate_next = gate_reg;
        nsrc_next = nsrc_reg;
        wr_pend_next = addr_take && I_HWRITE;
        wr_addr_next = addr_take ? word_ofs(I_HADDR) : wr_addr_reg;
        rdata_next = 32'h0000_0000;
        if (wr_pend_reg) begin
            if (wr_addr_reg == `PSCG_OFS_CLOCK_DIVIDER_REGISTER) begin
                clock_divider_register_next = {I_HWDATA[15:11], 11'h000};
            end else if (wr_addr_reg == `PSCG_OFS_GATE1) begin
                // RULE20: unused gate bits stay zero
                gate_next = I_HWDATA[15:0] & `PSCG_GATE1_MASK;
            end else if (wr_addr_reg == `PSCG_OFS_NEWSRC) begin
                // RULE21: source field locked by configuration
                if (I_SYS.clksw_en) begin
                    nsrc_next = I_HWDATA[`PSCG_NSRC_HI:`PSCG_NSRC_LO];
                end
            end
        end
        // RULE15: interrupt drops doze when recover bit set
        if (clock_divider_register_reg[`PSCG_ROI_BIT] && I_SYS.irq) begin
            clock_divider_register_next[`PSCG_DOZE_ENABLE_BIT_BIT] = 1'b0;
        end
        if (addr_take && !I_HWRITE) begin
            if (word_ofs(I_HADDR) == `PSCG_OFS_CLOCK_DIVIDER_REGISTER) begin
                rdata_next = {16'h0000, clock_divider_register_reg};
            end else if (word_ofs(I_HADDR) == `PSCG_OFS_GATE1) begin
                rdata_next = {16'h0000, gate_reg};
            end else if (word_ofs(I_HADDR) == `PSCG_OFS_NEWSRC) begin
                rdata_next = {21'h000000, nsrc_reg, 8'h00};
            end else if (word_ofs(I_HADDR) == `PSCG_OFS_STATUS) begin
                rdata_next = {24'h000000, src_reg, state_reg};
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            clock_divider_register_reg <= `PSCG_CLOCK_DIVIDER_REGISTER_RST;
            gate_reg <= `PSCG_GATE1_RST;
            nsrc_reg <= `PSCG_NSRC_RST;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 4'h0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            clock_divider_register_reg <= clock_divider_register_next;
            gate_reg <= gate_next;
            nsrc_reg <= nsrc_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg <= rdata_next;
        end
    end

    // Clock source, doze divider and gate delay
    always_comb begin
        src_next = src_reg;
        // RULE8: source frozen outside run
        if (state_reg == PSCG_RUN) begin
            src_next = I_SYS.clksw_en ? nsrc_reg : I_SYS.cfg_src;
        end
        // RULE22: count system clocks per ratio period
        if (!doze_on || cpu_tick) begin
            div_next = doze_on ? ratio_top : 7'h00;
        end else begin
            div_next = div_reg - 7'h01;
        end
        // RULE18: one instruction cycle of delay
        gate_dly_next = gate_reg;
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            src_reg <= `PSCG_NSRC_RST;
            div_reg <= 7'h00;
            gate_dly_reg <= `PSCG_GATE1_RST;
        end else begin
            src_reg <= src_next;
            div_reg <= div_next;
            gate_dly_reg <= gate_dly_next;
        end
    end

    // RULE1: CPU halted outside run
    // RULE12: doze thins only the CPU enable
    assign O_CPU_CLK_EN = (state_reg == PSCG_RUN) && (!doze_on || cpu_tick);
    // RULE2: idle keeps system clock
    // RULE4: sleep shuts the source
    assign O_SYS_CLK_EN = state_reg != PSCG_SLEEP;
    // RULE5: RC kept for watchdog in sleep
    // RULE9: RC kept for watchdog or monitor otherwise
    assign O_LOW_POWER_RC_OSCILLATOR_EN = I_SYS.wdt_en || (I_SYS.fail_safe_clock_monitor_en && state_reg != PSCG_SLEEP);
    // RULE4: monitor idle while source is off
    assign O_FAIL_SAFE_CLOCK_MONITOR_RUN = I_SYS.fail_safe_clock_monitor_en && state_reg != PSCG_SLEEP;
    // RULE7: sleep drops every module clock
    // RULE16: gated module loses clock and registers
    // RULE17: absent modules never enabled
    // RULE19: gate positions fixed by mask
    assign O_PERIPH_EN = (state_reg == PSCG_SLEEP) ? 16'h0000 : (PRESENT_MASK & `PSCG_GATE1_MASK & ~gate_dly_reg);
    assign O_WDT_CLEAR = wdt_clr_reg;
    assign O_WAKE = wake_reg;
    assign O_CLK_SRC = src_reg;
    assign O_HRDATA = rdata_reg;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    a_sleep_halts: assert property ( // RULE1
        state_reg == PSCG_SLEEP |-> !O_SYS_CLK_EN && !O_CPU_CLK_EN
    ) else $error("clocks running in sleep");
    a_idle_keeps_sys: assert property ( // RULE2
        state_reg == PSCG_IDLE |-> O_SYS_CLK_EN && !O_CPU_CLK_EN
    ) else $error("idle clocking wrong");
    a_wake_on_event: assert property ( // RULE3
        (state_reg == PSCG_SLEEP || state_reg == PSCG_IDLE) && I_SYS.irq
        |=> state_reg == PSCG_RUN && O_WAKE
    ) else $error("no wake on interrupt");
    a_low_power_rc_oscillator_sleep: assert property ( // RULE5
        state_reg == PSCG_SLEEP && I_SYS.wdt_en |-> O_LOW_POWER_RC_OSCILLATOR_EN && !O_FAIL_SAFE_CLOCK_MONITOR_RUN
    ) else $error("rc stopped in sleep");
    a_wdt_clear_entry: assert property ( // RULE6
        state_reg == PSCG_RUN && I_PSV.valid && I_SYS.wdt_en |=> O_WDT_CLEAR ##1 !O_WDT_CLEAR
    ) else $error("watchdog not cleared on entry");
    a_sleep_gates_off: assert property ( // RULE7
        state_reg == PSCG_SLEEP |-> O_PERIPH_EN == 16'h0000
    ) else $error("module clocked in sleep");
    a_src_frozen: assert property ( // RULE8
        state_reg == PSCG_SLEEP |=> $stable(O_CLK_SRC)
    ) else $error("source changed in sleep");
    a_held_irq_wakes: assert property ( // RULE11
        state_reg == PSCG_RUN && I_PSV.valid ##1 I_SYS.irq |=> ##1 state_reg == PSCG_RUN
    ) else $error("held interrupt lost");
    a_full_speed: assert property ( // RULE13
        state_reg == PSCG_RUN && !doze_on |-> O_CPU_CLK_EN
    ) else $error("cpu slowed without doze");
    a_gate_delay: assert property ( // RULE18
        state_reg == PSCG_RUN && PRESENT_MASK[0] && $rose(gate_reg[0])
        |-> O_PERIPH_EN[0] ##1 !O_PERIPH_EN[0]
    ) else $error("gate delay wrong");
    a_unused_zero: assert property ( // RULE20
        (gate_reg & ~`PSCG_GATE1_MASK) == 16'h0000
    ) else $error("unused gate bit set");
    a_src_locked: assert property ( // RULE21
        !I_SYS.clksw_en |=> $stable(nsrc_reg)
    ) else $error("locked source written");

    a_sleep_no_monitor: assert property ( // RULE4
        state_reg == PSCG_SLEEP
        |-> !O_FAIL_SAFE_CLOCK_MONITOR_RUN
    ) else $error("monitor running in sleep");

    a_idle_rc_on: assert property ( // RULE9
        state_reg == PSCG_IDLE && (I_SYS.wdt_en || I_SYS.fail_safe_clock_monitor_en)
        |-> O_LOW_POWER_RC_OSCILLATOR_EN
    ) else $error("rc stopped in idle");

    a_sys_on_awake: assert property ( // RULE9
        state_reg != PSCG_SLEEP
        |-> O_SYS_CLK_EN
    ) else $error("source off outside sleep");

    a_rc_off_unused: assert property ( // RULE5
        !I_SYS.wdt_en && !I_SYS.fail_safe_clock_monitor_en
        |-> !O_LOW_POWER_RC_OSCILLATOR_EN
    ) else $error("rc on without user");

    a_wake_on_timeout: assert property ( // RULE3
        (state_reg == PSCG_SLEEP || state_reg == PSCG_IDLE) && I_SYS.wdt_timeout
        |=> state_reg == PSCG_RUN && O_WAKE
    ) else $error("no wake on time-out");

    a_wake_single: assert property ( // RULE10
        O_WAKE
        |=> !O_WAKE
    ) else $error("wake pulse too long");

    a_wake_cpu_on: assert property ( // RULE10
        O_WAKE && !doze_on
        |-> O_CPU_CLK_EN
    ) else $error("cpu clock late after wake");

    a_entry_halts_cpu: assert property ( // RULE1
        state_reg == PSCG_ENT_SLEEP || state_reg == PSCG_ENT_IDLE
        |-> !O_CPU_CLK_EN
    ) else $error("cpu clocked during entry");

    a_held_irq_sleep: assert property ( // RULE11
        state_reg == PSCG_ENT_SLEEP && I_SYS.irq
        |=> ##1 state_reg == PSCG_RUN && O_WAKE
    ) else $error("held interrupt lost in sleep entry");

    a_no_clear_off: assert property ( // RULE6
        !I_SYS.wdt_en
        |=> !O_WDT_CLEAR
    ) else $error("watchdog cleared while disabled");

    a_roi_exits_doze: assert property ( // RULE15
        clock_divider_register_reg[`PSCG_ROI_BIT] && I_SYS.irq
        |=> !doze_on
    ) else $error("doze kept after interrupt");

    a_doze_kept: assert property ( // RULE15
        !clock_divider_register_reg[`PSCG_ROI_BIT] && doze_on && !wr_pend_reg
        |=> doze_on
    ) else $error("doze left without recover");

    a_absent_off: assert property ( // RULE17
        (O_PERIPH_EN & ~(PRESENT_MASK & `PSCG_GATE1_MASK)) == 16'h0000
    ) else $error("absent module enabled");

    a_gated_off: assert property ( // RULE16
        (O_PERIPH_EN & gate_dly_reg) == 16'h0000
    ) else $error("gated module enabled");

    a_gate_release: assert property ( // RULE18
        state_reg == PSCG_RUN && PRESENT_MASK[0] && $fell(gate_reg[0])
        |-> !O_PERIPH_EN[0] ##1 (O_PERIPH_EN[0] || state_reg == PSCG_SLEEP)
    ) else $error("gate release delay wrong");

    a_src_tracks_cfg: assert property ( // RULE8
        state_reg == PSCG_RUN && !I_SYS.clksw_en
        |=> O_CLK_SRC == $past(I_SYS.cfg_src)
    ) else $error("source not configured one");

    c_sleep_wake: cover property (state_reg == PSCG_SLEEP ##1 O_WAKE);
    c_idle_wake: cover property (state_reg == PSCG_IDLE ##1 O_WAKE);
    c_doze_slow: cover property (doze_on && clock_divider_register_reg[14:12] == 3'h7 && cpu_tick);
    c_gate_set: cover property ($rose(gate_reg[13]));
    c_roi_exit: cover property (clock_divider_register_reg[`PSCG_ROI_BIT] && doze_on && I_SYS.irq);
endmodule

/* File: testbench/pscg_core_model.sv */
// Purpose: CPU, watchdog and interrupt source beside the clock block
// Assumes: same clock; events change just after a rising edge
// Notes: counts CPU enables so doze rate can be measured
`timescale 1ns/1ps
module pscg_core_model
    import pscg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cpu_clk_en,
    output pscg_psv_t o_psv,
    output pscg_sys_t o_sys,
    output int o_ticks
);
    initial begin
        o_psv = '0;
        o_sys = '0;
    end
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ticks <= 0;
        end else if (i_cpu_clk_en === 1'b1) begin
            o_ticks <= o_ticks + 1;
        end
    end
    task automatic setup(input logic wdt, input logic fail_safe_clock_monitor, input logic sw, input logic [2:0] src);
        @(posedge i_clk);
        o_sys.wdt_en <= wdt;
        o_sys.fail_safe_clock_monitor_en <= fail_safe_clock_monitor;
        o_sys.clksw_en <= sw;
        o_sys.cfg_src <= src;
    endtask
    task automatic power_save(input logic idle);
        @(posedge i_clk);
        o_psv <= '{valid: 1'b1, idle_sel: idle};
        @(posedge i_clk);
        o_psv <= '0;
    endtask
    // Single-cycle wake source, the hardest case to catch
    task automatic pulse(input logic wdt);
        @(posedge i_clk);
        o_sys.irq <= !wdt;
        o_sys.wdt_timeout <= wdt;
        @(posedge i_clk);
        o_sys.irq <= 1'b0;
        o_sys.wdt_timeout <= 1'b0;
    endtask
endmodule

/* File: testbench/pscg_top_test.sv */
// Purpose: self-checking bench of the power-saving clock block
// Assumes: zero-wait bus slave, hready fed back from hreadyout
// Notes: bus samples taken at each falling edge, equal to the next rising-edge values
`timescale 1ns/1ps
`include "pscg_defs.svh"
module pscg_top_test;
    import pscg_pkg::*;
    localparam logic [31:0] A_DIV = {28'h0, `PSCG_OFS_CLOCK_DIVIDER_REGISTER};
    localparam logic [31:0] A_GATE = {28'h0, `PSCG_OFS_GATE1};
    localparam logic [31:0] A_SRC = {28'h0, `PSCG_OFS_NEWSRC};
    localparam logic [31:0] A_STAT = {28'h0, `PSCG_OFS_STATUS};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic hsel = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata, hrdata_s, rd;
    logic hready, hready_s, hresp, cpu_en, sys_en, low_power_rc_oscillator_en, fail_safe_clock_monitor_run, wdt_clr, wake;
    logic [2:0] clk_src;
    logic [15:0] periph_en;
    pscg_psv_t psv;
    pscg_sys_t sys;
    int ticks, t0;
    int errors = 0;
    int checks = 0;
    int gate_bits [8] = '{13, 12, 11, 9, 7, 5, 3, 0};
    always #5 clk = ~clk;
    always @(negedge clk) begin
        hrdata_s = hrdata;
        hready_s = hready;
    end
    pscg_core_model core (.i_clk(clk), .i_rst_b(rst_b), .i_cpu_clk_en(cpu_en), .o_psv(psv), .o_sys(sys),
        .o_ticks(ticks));
    pscg_top dut (.I_CLK(clk), .I_RST_B(rst_b), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .I_PSV(psv), .I_SYS(sys), .O_CPU_CLK_EN(cpu_en),
        .O_SYS_CLK_EN(sys_en), .O_LOW_POWER_RC_OSCILLATOR_EN(low_power_rc_oscillator_en), .O_FAIL_SAFE_CLOCK_MONITOR_RUN(fail_safe_clock_monitor_run), .O_WDT_CLEAR(wdt_clr),
        .O_WAKE(wake), .O_CLK_SRC(clk_src), .O_PERIPH_EN(periph_en));
    task automatic complete_run;
        $display("Mismatches %0d, comparisons %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait, a stuck slave ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready_s !== 1'b1 && n < 16);
        if (hready_s !== 1'b1) begin
            errors++;
            complete_run();
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= a;
        hwrite <= wr;
        hsel <= 1'b1;
        hsize <= 3'h2;
        htrans <= `PSCG_HTRANS_NSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata_s;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, what);
        chk(32'(hresp), 32'h0, "bus response");
    endtask
    task automatic count(input int n, input int exp);
        cyc(2);
        t0 = ticks;
        cyc(n);
        chk(32'(ticks - t0), 32'(exp), "cpu ticks");
    endtask
    task automatic wait_wake;
        int n;
        n = 0;
        #1;
        while (wake !== 1'b1 && n < 8) begin
            cyc(1);
            n++;
        end
        chk(32'(wake), 32'h1, "wake pulse");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rdc(A_DIV, 32'h0, "divider reset");
        rdc(A_GATE, 32'h0, "gate reset");
        chk(periph_en, 32'h3AA9, "enables at reset");
        bus(1'b1, A_GATE, 32'hFFFF);
        #1;
        chk(periph_en, 32'h3AA9, "gate delay");
        cyc(1);
        chk(periph_en, 32'h0, "all gated");
        rdc(A_GATE, 32'h3AA9, "gate bits");
        foreach (gate_bits[i]) begin
            bus(1'b1, A_GATE, 32'h1 << gate_bits[i]);
            cyc(1);
            chk(periph_en, 32'h3AA9 ^ (32'h1 << gate_bits[i]), "single gate");
        end
        bus(1'b1, A_GATE, 32'h0);
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, A_DIV, 32'h0FFF | (32'(k) << 12));
            rdc(A_DIV, 32'h0800 | (32'(k) << 12), "divider bits");
            count(256, 256 >> k);
            chk({sys_en, periph_en}, 32'h13AA9, "peripherals full rate");
        end
        bus(1'b1, A_DIV, 32'h7000);
        count(256, 256);
        bus(1'b1, A_DIV, 32'hB800);
        core.pulse(1'b0);
        rdc(A_DIV, 32'hB000, "recover clears doze");
        count(64, 64);
        bus(1'b1, A_DIV, 32'h3800);
        core.pulse(1'b0);
        rdc(A_DIV, 32'h3800, "doze kept");
        bus(1'b1, A_DIV, 32'h0);
        bus(1'b1, A_SRC, 32'h0500);
        rdc(A_SRC, 32'h0, "source locked");
        core.setup(1'b1, 1'b1, 1'b1, 3'h3);
        bus(1'b1, A_SRC, 32'h0500);
        rdc(A_SRC, 32'h0500, "source open");
        rdc(A_STAT, 32'hA1, "run status");
        core.power_save(1'b0);
        #1;
        chk({cpu_en, wdt_clr}, 32'h1, "sleep entry");
        cyc(1);
        chk({sys_en, low_power_rc_oscillator_en, fail_safe_clock_monitor_run, periph_en}, 32'h20000, "in sleep");
        rdc(A_STAT, 32'hA8, "sleep status");
        core.pulse(1'b0);
        wait_wake();
        chk({cpu_en, sys_en, clk_src}, 32'h1D, "sleep wake");
        core.setup(1'b0, 1'b1, 1'b1, 3'h3);
        core.power_save(1'b1);
        #1;
        chk({cpu_en, wdt_clr}, 32'h0, "idle entry");
        cyc(1);
        chk({sys_en, low_power_rc_oscillator_en, fail_safe_clock_monitor_run, periph_en}, 32'h73AA9, "in idle");
        core.pulse(1'b1);
        wait_wake();
        chk(32'(cpu_en), 32'h1, "idle wake");
        fork
            core.power_save(1'b1);
            begin
                @(posedge clk);
                core.pulse(1'b0);
            end
        join
        wait_wake();
        core.power_save(1'b0);
        cyc(2);
        @(posedge clk);
        rst_b <= 1'b0;
        #1;
        chk({cpu_en, sys_en}, 32'h3, "reset wake");
        @(posedge clk);
        rst_b <= 1'b1;
        cyc(2);
        complete_run();
    end
endmodule
